// File: src/fpvs_seq.sv
// flash program/verify sequencer top: control registers, page capture, pulse timing
// assumes the cpu port is on mclk_i and the write-protect pin is asynchronous
`timescale 1ns/1ps
`include "fpvs_defines.svh"
// Behaviour
// [R1] one page is exactly 32 bytes
// [R2] software waits 10 us after gate
// [R3] page start address is 32-byte aligned
// [R4] latch page address and 32 data bytes
// [R5] unused bytes written as ff
// [R6] software arms watchdog, 300 us minimum
// [R7] setup then 50 us before pulse
// [R8] cells program only while pulse set
// [R9] clear pulse, then setup 10 us later
// [R10] disable watchdog, then set verify
// [R11] dummy ff write 4 us after verify
// [R12] 2 us between dummy write and read
// [R13] verify reads return latched data words
// [R14] software computes reprogram data
// [R15] clear verify, wait, clear gate
// [R16] at most 1000 retries per bits
// [R17] lower register low bank, upper high
// [R18] no programming while protect pin high
// [R19] normal reads blocked during program
// [R20] mode bits ignored without write gate
module fpvs_seq
  import fpvs_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [17:0] fl_addr_i,
  input  wire logic [7:0]  fl_wdata_i,
  input  wire logic        fl_wr_i,
  input  wire logic        fl_rd_i,
  output logic      [31:0] fl_rdata_o,
  output logic             fl_rd_err_o,
  input  wire logic        write_protect_pin_i,
  output logic             prog_pulse_o,
  output logic             prog_bank_o,
  output logic      [17:0] prog_addr_o
);
  // control register bits
  logic       gate_ff, nxt_gate;
  logic [1:0] setup_ff, nxt_setup;
  logic [1:0] pulse_ff, nxt_pulse;
  logic [1:0] verify_ff, nxt_verify;
  logic [7:0] rdata_ff, nxt_rdata;
  // page capture
  fpvs_state_t state_ff, nxt_state;
  logic [17:0] base_ff, nxt_base;
  logic [5:0]  cnt_ff, nxt_cnt;
  logic        align_err_ff, nxt_align_err;
  logic        full_ff, nxt_full;
  // pulse timer, counts cycles of the current pulse
  logic [15:0] ptime_ff, nxt_ptime;
  logic        pdone_ff, nxt_pdone;
  // outputs towards cpu flash read
  logic [31:0] frd_ff, nxt_frd;
  logic        ferr_ff, nxt_ferr;
  // protect pin synchroniser
  logic        wp_meta_ff, wp_sync_ff;

  fpvs_page_if pg ();

  fpvs_page_latch u_latch (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pg     (pg)
  );

  function automatic logic [7:0] ctrl_image(input logic g, input logic s, input logic p, input logic v);
    logic [7:0] r;
    r = 8'h00;
    r[`FPVS_BIT_GATE]   = g;
    r[`FPVS_BIT_SETUP]  = s;
    r[`FPVS_BIT_PULSE]  = p;
    r[`FPVS_BIT_VERIFY] = v;
    return r;
  endfunction : ctrl_image

  // two flops before the pin reaches any logic
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_meta_ff <= 1'b1;
      wp_sync_ff <= 1'b1;
    end else begin
      wp_meta_ff <= write_protect_pin_i;
      wp_sync_ff <= wp_meta_ff;
    end
  end

  logic wr_lo, wr_hi, any_busy;
  assign wr_lo    = reg_wr_i && (reg_addr_i == `FPVS_OFF_CTRL_LO);
  assign wr_hi    = reg_wr_i && (reg_addr_i == `FPVS_OFF_CTRL_HI);
  assign any_busy = (|setup_ff) || (|pulse_ff);

  // control register update; gate lives only in the lower register
  always_comb begin
    nxt_gate   = gate_ff;
    nxt_setup  = setup_ff;
    nxt_pulse  = pulse_ff;
    nxt_verify = verify_ff;
    if (wr_lo) begin
      nxt_gate     = reg_wdata_i[`FPVS_BIT_GATE];
      nxt_setup[0] = reg_wdata_i[`FPVS_BIT_SETUP];
      nxt_pulse[0] = reg_wdata_i[`FPVS_BIT_PULSE];
      nxt_verify[0] = reg_wdata_i[`FPVS_BIT_VERIFY];
    end
    if (wr_hi) begin
      nxt_setup[1]  = reg_wdata_i[`FPVS_BIT_SETUP];
      nxt_pulse[1]  = reg_wdata_i[`FPVS_BIT_PULSE];
      nxt_verify[1] = reg_wdata_i[`FPVS_BIT_VERIFY];
    end
    // mode bits cannot hold while the gate is clear
    if (!nxt_gate) begin
      nxt_setup  = 2'b00; // R20
      nxt_pulse  = 2'b00; // R20
      nxt_verify = 2'b00; // R20
    end
    // a pulse needs its bank's setup standing both before and after the write
    nxt_pulse = nxt_pulse & setup_ff & nxt_setup;
  end

  // read mux; status shows sequencer state for software
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `FPVS_OFF_CTRL_LO: nxt_rdata = ctrl_image(gate_ff, setup_ff[0], pulse_ff[0], verify_ff[0]);
        `FPVS_OFF_CTRL_HI: nxt_rdata = ctrl_image(1'b0, setup_ff[1], pulse_ff[1], verify_ff[1]);
        `FPVS_OFF_STATUS:  nxt_rdata = {wp_sync_ff, pdone_ff, align_err_ff, full_ff, state_ff};
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  // page capture and verify state machine
  always_comb begin
    nxt_state     = state_ff;
    nxt_base      = base_ff;
    nxt_cnt       = cnt_ff;
    nxt_align_err = align_err_ff;
    nxt_full      = full_ff;
    pg.wr_en      = 1'b0;
    pg.wr_idx     = fl_addr_i[4:0];
    pg.wr_data    = fl_wdata_i;
    pg.clr        = 1'b0;
    unique case (state_ff)
      FPVS_IDLE: begin
        if (gate_ff && fl_wr_i && !any_busy && !(|verify_ff)) begin
          nxt_base      = {fl_addr_i[17:5], 5'h00}; // R4
          nxt_align_err = (fl_addr_i[4:0] != 5'h00);
          pg.clr        = 1'b1;
          pg.wr_en      = 1'b1; // R4
          nxt_cnt       = 6'd1;
          nxt_full      = 1'b0;
          nxt_state     = FPVS_LOAD;
        end
      end
      FPVS_LOAD: begin
        if (fl_wr_i) begin
          pg.wr_en = 1'b1; // R1
          nxt_cnt  = cnt_ff + 6'd1;
          if (cnt_ff == 6'(`FPVS_PAGE_BYTES - 1)) begin
            nxt_full = 1'b1; // R1
          end
        end
        if (|setup_ff) begin
          nxt_state = FPVS_PROG;
        end
      end
      FPVS_PROG: begin
        if (|verify_ff) begin
          nxt_state = FPVS_VERIFY;
        end else if (!gate_ff) begin
          nxt_state = FPVS_IDLE;
        end
      end
      FPVS_VERIFY: begin
        // a retry goes back through setup with the same latched page
        if (|setup_ff) begin
          nxt_state = FPVS_PROG;
        end else if (!gate_ff) begin
          nxt_state = FPVS_IDLE;
        end
      end
      default: nxt_state = FPVS_IDLE;
    endcase
    if (!gate_ff) begin
      nxt_state = FPVS_IDLE;
    end
  end

  // pulse enable to the array only when unprotected and bank matches page
  logic bank_sel;
  assign bank_sel = base_ff[`FPVS_BANK_BIT];
  logic pulse_live;
  assign pulse_live = pulse_ff[bank_sel] && !wp_sync_ff && !pdone_ff; // R8 R17 R18

  // pulse timer stops the array after the nominal time as a runaway guard
  always_comb begin
    nxt_ptime = ptime_ff;
    nxt_pdone = pdone_ff;
    if (!(|pulse_ff)) begin
      nxt_ptime = 16'h0000;
      nxt_pdone = 1'b0;
    end else if (pulse_live) begin
      nxt_ptime = ptime_ff + 16'h0001;
      if (ptime_ff == 16'(`FPVS_PULSE_CYC - 1)) begin
        nxt_pdone = 1'b1; // R8
      end
    end
  end

  // flash read port: verify word from latch, normal reads refused while busy
  logic [2:0] word_idx;
  assign word_idx   = fl_addr_i[4:2];
  assign pg.rd_word = word_idx;
  always_comb begin
    nxt_frd  = frd_ff;
    nxt_ferr = 1'b0;
    if (fl_rd_i) begin
      if (any_busy) begin
        nxt_frd  = 32'hffffffff; // R19
        nxt_ferr = 1'b1; // R19
      end else if (verify_ff[fl_addr_i[`FPVS_BANK_BIT]]) begin
        nxt_frd = pg.rd_data; // R13
      end else begin
        nxt_frd = 32'hffffffff;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gate_ff      <= 1'b0;
      setup_ff     <= 2'b00;
      pulse_ff     <= 2'b00;
      verify_ff    <= 2'b00;
      rdata_ff     <= `FPVS_CTRL_RST;
      state_ff     <= FPVS_IDLE;
      base_ff      <= 18'h00000;
      cnt_ff       <= 6'd0;
      align_err_ff <= 1'b0;
      full_ff      <= 1'b0;
      ptime_ff     <= 16'h0000;
      pdone_ff     <= 1'b0;
      frd_ff       <= 32'h00000000;
      ferr_ff      <= 1'b0;
    end else begin
      gate_ff      <= nxt_gate;
      setup_ff     <= nxt_setup;
      pulse_ff     <= nxt_pulse;
      verify_ff    <= nxt_verify;
      rdata_ff     <= nxt_rdata;
      state_ff     <= nxt_state;
      base_ff      <= nxt_base;
      cnt_ff       <= nxt_cnt;
      align_err_ff <= nxt_align_err;
      full_ff      <= nxt_full;
      ptime_ff     <= nxt_ptime;
      pdone_ff     <= nxt_pdone;
      frd_ff       <= nxt_frd;
      ferr_ff      <= nxt_ferr;
    end
  end

  assign reg_rdata_o  = rdata_ff;
  assign fl_rdata_o   = frd_ff;
  assign fl_rd_err_o  = ferr_ff;
  assign prog_pulse_o = pulse_live;
  assign prog_bank_o  = bank_sel;
  assign prog_addr_o  = base_ff;

  // checks next to the logic they guard
  AST_GATE_CLEARS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !gate_ff |-> (setup_ff == 2'b00) && (pulse_ff == 2'b00) && (verify_ff == 2'b00))
    else $error("mode bit standing without gate"); // R20
  AST_WP_BLOCK: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    wp_sync_ff |-> !prog_pulse_o)
    else $error("pulse while protected"); // R18
  AST_PULSE_NEEDS_BIT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    prog_pulse_o |-> pulse_ff[prog_bank_o] && setup_ff[prog_bank_o])
    else $error("pulse without its bank bits"); // R8
  AST_BANK_MAP: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    prog_pulse_o |-> pulse_ff[prog_addr_o[17]] && (prog_bank_o == prog_addr_o[17]))
    else $error("bank does not match page address"); // R17
  AST_CAPTURE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state_ff == FPVS_IDLE) && gate_ff && fl_wr_i && !any_busy && !(|verify_ff)
    |=> (state_ff == FPVS_LOAD) && (base_ff[4:0] == 5'h00) && (cnt_ff == 6'd1))
    else $error("page start not captured"); // R4
  AST_FULL: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (state_ff == FPVS_LOAD) && fl_wr_i && (cnt_ff == 6'd31) |=> full_ff)
    else $error("page full flag missed"); // R1
  AST_BUSY_READ: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    fl_rd_i && any_busy |=> fl_rd_err_o && (fl_rdata_o == 32'hffffffff))
    else $error("read not refused while busy"); // R19
  AST_VERIFY_DATA: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    fl_rd_i && !any_busy && verify_ff[fl_addr_i[17]] |=> (fl_rdata_o == $past(pg.rd_data)))
    else $error("verify word wrong"); // R13
  AST_READ_ONE_CYCLE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    fl_rd_err_o |-> $past(fl_rd_i))
    else $error("error flag without read"); // R19
  COV_LOAD: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(full_ff));
  COV_PULSE: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(prog_pulse_o));
  COV_VERIFY: cover property (@(posedge mclk_i) disable iff (!nrst_i) state_ff == FPVS_VERIFY);
  COV_RETRY: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    (state_ff == FPVS_VERIFY) ##1 (state_ff == FPVS_PROG));
endmodule : fpvs_seq

// File: src/fpvs_defines.svh
// constants for the flash program/verify sequencer
// assumes inclusion by bare name from design files
`ifndef FPVS_DEFINES_SVH
`define FPVS_DEFINES_SVH
`define FPVS_OFF_CTRL_LO    8'h80
`define FPVS_OFF_CTRL_HI    8'h81
`define FPVS_OFF_STATUS     8'h82
`define FPVS_CTRL_RST       8'h00
`define FPVS_BIT_GATE       6
`define FPVS_BIT_SETUP      4
`define FPVS_BIT_VERIFY     2
`define FPVS_BIT_PULSE      0
`define FPVS_PAGE_BYTES     32
`define FPVS_PAGE_WORDS     8
`define FPVS_BANK_BIT       17
`define FPVS_ADDR_W         18
`define FPVS_CLK_MHZ        250
`define FPVS_PULSE_US       200
`define FPVS_PULSE_CYC      (`FPVS_PULSE_US * `FPVS_CLK_MHZ)
`endif

// File: src/fpvs_pkg.sv
// types for the flash program/verify sequencer
// assumes fpvs_defines.svh is on the include path
package fpvs_pkg;
  typedef enum logic [3:0] {
    FPVS_IDLE   = 4'b0001,
    FPVS_LOAD   = 4'b0010,
    FPVS_PROG   = 4'b0100,
    FPVS_VERIFY = 4'b1000
  } fpvs_state_t;
endpackage : fpvs_pkg

// File: src/fpvs_page_if.sv
// page latch carrier between the sequencer and its latch
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface fpvs_page_if;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic [7:0]  wr_data;
  logic        clr;
  logic [2:0]  rd_word;
  logic [31:0] rd_data;
  modport ctrl  (output wr_en, output wr_idx, output wr_data, output clr, output rd_word, input rd_data);
  modport latch (input wr_en, input wr_idx, input wr_data, input clr, input rd_word, output rd_data);
endinterface : fpvs_page_if

// File: src/fpvs_page_latch.sv
// 32-byte page latch built from flip-flops
// assumes writes come from the sequencer on mclk_i
`timescale 1ns/1ps
`include "fpvs_defines.svh"
module fpvs_page_latch
  import fpvs_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  fpvs_page_if.latch pg
);
  logic [7:0] byte_ff [`FPVS_PAGE_BYTES];
  logic [7:0] nxt_byte [`FPVS_PAGE_BYTES];

  // erased pattern on clear so unwritten bytes leave cells untouched
  always_comb begin
    for (int i = 0; i < `FPVS_PAGE_BYTES; i++) begin
      nxt_byte[i] = byte_ff[i];
      if (pg.clr) begin
        nxt_byte[i] = 8'hff;
      end
      if (pg.wr_en && (pg.wr_idx == 5'(i))) begin
        nxt_byte[i] = pg.wr_data; // R4
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < `FPVS_PAGE_BYTES; i++) begin
        byte_ff[i] <= 8'hff;
      end
    end else begin
      for (int i = 0; i < `FPVS_PAGE_BYTES; i++) begin
        byte_ff[i] <= nxt_byte[i];
      end
    end
  end

  // big-endian word assembly, byte 0 in the top lane
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign pg.rd_data[31-8*g -: 8] = byte_ff[{pg.rd_word, 2'(g)}]; // R13
    end
  endgenerate
endmodule : fpvs_page_latch

// File: test/fpvs_cpu_model.sv
// cpu-side model of the flash byte store / word read port
// assumes it shares mclk_i with the sequencer and is driven by tasks
`timescale 1ns/1ps
module fpvs_cpu_model (
  input  wire logic        mclk_i,
  output logic      [17:0] fl_addr_o,
  output logic      [7:0]  fl_wdata_o,
  output logic             fl_wr_o,
  output logic             fl_rd_o
);
  initial begin
    fl_addr_o  = 18'h00000;
    fl_wdata_o = 8'h00;
    fl_wr_o    = 1'b0;
    fl_rd_o    = 1'b0;
  end

  // one byte store; released lines flip so a stale value is never trusted
  task automatic wr_byte(input logic [17:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    fl_addr_o  <= a;
    fl_wdata_o <= d;
    fl_wr_o    <= 1'b1;
    @(posedge mclk_i);
    fl_wr_o    <= 1'b0;
    fl_addr_o  <= ~a;
    fl_wdata_o <= ~d;
  endtask : wr_byte

  // one word read, answer is checked by the bench monitor
  task automatic rd_word(input logic [17:0] a);
    @(posedge mclk_i);
    fl_addr_o <= a;
    fl_rd_o   <= 1'b1;
    @(posedge mclk_i);
    fl_rd_o   <= 1'b0;
    fl_addr_o <= ~a;
  endtask : rd_word

  // whole page from an aligned start, unused bytes already ff in pg
  task automatic wr_page(input logic [17:0] base, input logic [255:0] pg);
    for (int i = 0; i < 32; i++) wr_byte(base + 18'(i), pg[8*i +: 8]);
  endtask : wr_page
endmodule : fpvs_cpu_model

// File: test/fpvs_seq_test.sv
// self-checking bench for the flash program/verify sequencer
// assumes the cpu model drives the flash port and the bench the register port
`timescale 1ns/1ps
module fpvs_seq_test;
  localparam int US = 250; // clock cycles per microsecond
  logic         mclk_i      = 1'b0;
  logic         nrst_i      = 1'b0;
  logic [7:0]   reg_addr_i  = 8'h00;
  logic [7:0]   reg_wdata_i = 8'h00;
  logic         reg_wr_i    = 1'b0;
  logic         reg_rd_i    = 1'b0;
  logic         wp_i        = 1'b0;
  logic         rd_d        = 1'b0;
  logic         frd_d       = 1'b0;
  logic [7:0]   reg_rdata_o;
  logic [17:0]  fl_addr;
  logic [7:0]   fl_wdata;
  logic         fl_wr;
  logic         fl_rd;
  logic [31:0]  fl_rdata_o;
  logic         fl_rd_err_o;
  logic         prog_pulse_o;
  logic         prog_bank_o;
  logic [17:0]  prog_addr_o;
  logic [7:0]   reg_q [$];
  logic [32:0]  fl_q [$];
  int           miscompares = 0;
  int           checks      = 0;
  logic [17:0]  base;
  logic         bank;
  logic [255:0] pg;
  logic [7:0]   ca;
  logic [7:0]   gb;

  always #2 mclk_i = ~mclk_i;

  fpvs_seq u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_addr_i(fl_addr),
    .fl_wdata_i(fl_wdata), .fl_wr_i(fl_wr), .fl_rd_i(fl_rd), .fl_rdata_o(fl_rdata_o),
    .fl_rd_err_o(fl_rd_err_o), .write_protect_pin_i(wp_i), .prog_pulse_o(prog_pulse_o),
    .prog_bank_o(prog_bank_o), .prog_addr_o(prog_addr_o));

  fpvs_cpu_model u_cpu (.mclk_i(mclk_i), .fl_addr_o(fl_addr), .fl_wdata_o(fl_wdata), .fl_wr_o(fl_wr),
    .fl_rd_o(fl_rd));

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  task automatic end_of_test();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // register write, lines flip when released
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
    reg_addr_i  <= ~a;
    reg_wdata_i <= ~d;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    reg_q.push_back(e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    reg_addr_i <= ~a;
  endtask : reg_rd

  task automatic wait_us(input int n);
    repeat (n * US) @(posedge mclk_i);
  endtask : wait_us

  task automatic chk_pulse(input logic e);
    @(negedge mclk_i);
    cmp({32'h0, prog_pulse_o}, {32'h0, e});
  endtask : chk_pulse

  // register answers and the flash error flag stand only in the cycle after the strobe, so compare there
  always @(posedge mclk_i) begin
    rd_d  <= reg_rd_i;
    frd_d <= fl_rd;
  end
  always @(negedge mclk_i) begin
    if (rd_d && reg_q.size() > 0) cmp({25'h0, reg_rdata_o}, {25'h0, reg_q.pop_front()});
    if (frd_d && fl_q.size() > 0) cmp({fl_rd_err_o, fl_rdata_o}, fl_q.pop_front());
  end

  // hang guard, a full run takes about 79200 cycles
  initial begin
    repeat (100000) @(posedge mclk_i);
    miscompares++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h0f302616));
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    reg_rd(8'h80, 8'h00);
    reg_rd(8'h81, 8'h00);
    reg_rd(8'h82, 8'h01);
    reg_rd(8'h83, 8'h00);
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h80 + 8'(i % 2), 8'($urandom()) & 8'hbf);
      reg_rd(8'h80 + 8'(i % 2), 8'h00);
    end
    reg_wr(8'h80, 8'h40);
    reg_wr(8'h80, 8'h41);
    reg_rd(8'h80, 8'h40);
    wait_us(10);
    bank = 1'($urandom());
    base = {bank, 12'($urandom()), 5'h00};
    ca   = 8'h80 + {7'h0, bank};
    gb   = bank ? 8'h00 : 8'h40;
    for (int i = 0; i < 32; i++) pg[8*i +: 8] = (i >= 28) ? 8'hff : 8'($urandom());
    u_cpu.wr_page(base, pg);
    @(negedge mclk_i);
    cmp({14'h0, prog_bank_o, prog_addr_o}, {14'h0, bank, base});
    reg_rd(8'h82, 8'h12);
    reg_wr(ca, gb | 8'h10);
    wait_us(50);
    reg_wr(ca, gb | 8'h11);
    chk_pulse(1'b1);
    @(posedge mclk_i);
    wp_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk_pulse(1'b0);
    @(posedge mclk_i);
    wp_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk_pulse(1'b1);
    fl_q.push_back({1'b1, 32'hffffffff});
    u_cpu.rd_word(base);
    wait_us(190);
    chk_pulse(1'b1);
    wait_us(12);
    chk_pulse(1'b0);
    reg_wr(ca, gb | 8'h10);
    wait_us(10);
    reg_wr(ca, gb);
    wait_us(10);
    reg_wr(ca, gb | 8'h04);
    wait_us(4);
    reg_rd(ca, gb | 8'h04);
    for (int i = 0; i < 8; i++) begin
      u_cpu.wr_byte(base + 18'(4 * i), 8'hff);
      wait_us(2);
      fl_q.push_back({1'b0, pg[32*i +: 8], pg[32*i+8 +: 8], pg[32*i+16 +: 8], pg[32*i+24 +: 8]});
      u_cpu.rd_word(base + 18'(4 * i));
    end
    fl_q.push_back({1'b0, 32'hffffffff});
    u_cpu.rd_word(base ^ 18'h20000);
    reg_wr(ca, gb);
    wait_us(4);
    // one retry pass back through setup, far below the retry limit
    reg_wr(ca, gb | 8'h10);
    reg_rd(8'h82, 8'h14);
    reg_wr(ca, gb);
    wait_us(10);
    reg_wr(8'h80, 8'h00);
    reg_rd(8'h80, 8'h00);
    repeat (4) @(posedge mclk_i);
    end_of_test();
  end
endmodule : fpvs_seq_test
